/* File: afc_params.svh */
/*
 * Offsets, reset values and field positions of the analog front-end
 * configuration registers. Assumes inclusion by afc_route_decode and afc_regs.
 */
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define AFC_IDX_ROUTE     8'h0d
`define AFC_IDX_LEVEL     8'h0e
`define AFC_IDX_RSVD      8'h0f
`define AFC_IDX_AMP       8'h10
`define AFC_IDX_INSEL     8'h11

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AFC_RST_ROUTE     8'hff
`define AFC_RST_LEVEL     8'h00
`define AFC_RST_AMP       8'h00
`define AFC_RST_INSEL     8'hff

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define AFC_HI_LSB        4
`define AFC_BYPASS_BIT    7
`define AFC_GAIN_MSB      2

// ----------------------------------------------------------------------------
// code limits
// ----------------------------------------------------------------------------
`define AFC_ROUTE_COMMON  4'ha
`define AFC_LEVEL_MAX2    4'h9
`define AFC_LEVEL_MAX1    4'ha

`endif

/* File: afc_pkg.sv */
/*
 * Types shared by the front-end configuration block.
 * Assumes afc_params.svh is on the include path.
 */
package afc_pkg;
    typedef enum logic [1:0] {
        AFC_BUS_IDLE = 2'b01,
        AFC_BUS_ACK  = 2'b10
    } afc_bus_state_type;

    typedef enum logic [1:0] {
        AFC_ROUTE_INPUT  = 2'h0,
        AFC_ROUTE_COMMON = 2'h1,
        AFC_ROUTE_NONE   = 2'h2
    } afc_route_kind_type;
endpackage

/* File: afc_route_decode.sv */
/*
 * Decodes one current-source routing nibble and one magnitude nibble.
 * Assumes a static nibble from the register bank; purely combinational.
 */
`timescale 1ns/1ps
`include "afc_params.svh"

module afc_route_decode
    import afc_pkg::*;
#(
    parameter logic [3:0] LEVEL_MAX = 4'h9
) (
    input  wire logic [3:0]   route_i,   // routing code
    input  wire logic [3:0]   level_i,   // magnitude code
    output afc_route_kind_type kind_o,   // kind of connection
    output logic [9:0]        pin_o,     // one-hot analog input
    output logic [3:0]        level_o    // 0 = off, else step 1..10
);
    // refused at elaboration: the step output only reaches 2500 uA
    if (LEVEL_MAX > 4'ha) begin : g_bad_limit
        $error("level limit out of range");
    end

    wire route_pin = route_i < `AFC_ROUTE_COMMON;
    wire level_ok  = level_i <= LEVEL_MAX;

    assign kind_o  = route_pin ? AFC_ROUTE_INPUT :
                     (route_i == `AFC_ROUTE_COMMON) ? AFC_ROUTE_COMMON : AFC_ROUTE_NONE;
    assign pin_o   = route_pin ? (10'h001 << route_i) : 10'h000;
    // codes beyond the limit decode as off
    assign level_o = level_ok ? level_i : 4'h0;
endmodule // afc_route_decode

/* File: afc_regs.sv */
/*
 * Analog front-end configuration registers behind a classic Wishbone slave.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "afc_params.svh"

module afc_regs
    import afc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,               // 100 MHz clock
    input  wire logic              rst_i,               // sync reset, high
    input  wire logic              cyc_i,               // wishbone cycle
    input  wire logic              stb_i,               // wishbone strobe
    input  wire logic              we_i,                // write enable
    input  wire logic [ADDR_W-1:0] adr_i,               // byte address
    input  wire logic [3:0]        sel_i,               // byte lanes
    input  wire logic [31:0]       dat_i,               // write data
    output logic      [31:0]       dat_o,               // read data
    output logic                   ack_o,               // acknowledge
    output logic                   err_o,               // unmapped address
    output afc_route_kind_type     second_route_kind_o, // second source kind
    output logic      [9:0]        second_route_pin_o,  // second source pin
    output logic      [3:0]        second_level_o,      // second source step
    output afc_route_kind_type     first_route_kind_o,  // first source kind
    output logic      [9:0]        first_route_pin_o,   // first source pin
    output logic      [3:0]        first_level_o,       // first source step
    output logic                   amp_bypass_o,        // amplifier bypassed
    output logic      [7:0]        gain_o,              // one-hot gain 1..128
    output logic      [3:0]        positive_input_select_o, // positive code
    output logic      [3:0]        negative_input_select_o  // negative code
);
    // refused at elaboration: the selector sits at byte address 44h
    if (ADDR_W < 7) begin : g_bad_width
        $error("address too narrow for register map");
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]        current_source_routing;
    logic [7:0]        current_source_magnitude;
    logic [7:0]        amplifier_config;
    logic [7:0]        input_selector;
    afc_bus_state_type state;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    wire req      = cyc_i && stb_i && (state == AFC_BUS_IDLE);
    wire hit_rt   = hit(adr_i, `AFC_IDX_ROUTE);
    wire hit_lv   = hit(adr_i, `AFC_IDX_LEVEL);
    wire hit_rs   = hit(adr_i, `AFC_IDX_RSVD);
    wire hit_am   = hit(adr_i, `AFC_IDX_AMP);
    wire hit_in   = hit(adr_i, `AFC_IDX_INSEL);
    wire mapped   = hit_rt || hit_lv || hit_rs || hit_am || hit_in;
    wire wr_low   = req && we_i && sel_i[0] && mapped;

    // reserved location reads zero, writes ignored
    wire [7:0] rd_byte = hit_rt ? current_source_routing :
                         hit_lv ? current_source_magnitude :
                         hit_am ? amplifier_config :
                         hit_in ? input_selector : 8'h00;

    // ------------------------------------------------------------------------
    // bus slave: one wait state, ack or err for one cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= AFC_BUS_IDLE;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            case (state)
                AFC_BUS_IDLE: begin
                    ack_o <= req && mapped;
                    err_o <= req && !mapped;
                    dat_o <= {24'h00_0000, rd_byte};
                    if (req) state <= AFC_BUS_ACK;
                end
                AFC_BUS_ACK: begin
                    ack_o <= 1'b0;
                    err_o <= 1'b0;
                    state <= AFC_BUS_IDLE;
                end
                default: state <= AFC_BUS_IDLE;
            endcase
        end
    end

    // the write lands on the same edge the ack rises, so a read-back after
    // the ack always sees the new value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_source_routing   <= `AFC_RST_ROUTE;
            current_source_magnitude <= `AFC_RST_LEVEL;
            amplifier_config         <= `AFC_RST_AMP;
            input_selector           <= `AFC_RST_INSEL;
        end else if (wr_low) begin
            if (hit_rt) current_source_routing   <= dat_i[7:0];
            if (hit_lv) current_source_magnitude <= dat_i[7:0];
            // reserved bits 6:3 are stored as written; software keeps them zero
            if (hit_am) amplifier_config         <= dat_i[7:0];
            if (hit_in) input_selector           <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------------
    // ambiguity resolved: first source keeps 2500 uA at code 1010
    afc_route_decode #(
        .LEVEL_MAX (`AFC_LEVEL_MAX2)
    ) u_second (
        .route_i (current_source_routing[7:`AFC_HI_LSB]),
        .level_i (current_source_magnitude[7:`AFC_HI_LSB]),
        .kind_o  (second_route_kind_o),
        .pin_o   (second_route_pin_o),
        .level_o (second_level_o)
    );

    afc_route_decode #(
        .LEVEL_MAX (`AFC_LEVEL_MAX1)
    ) u_first (
        .route_i (current_source_routing[3:0]),
        .level_i (current_source_magnitude[3:0]),
        .kind_o  (first_route_kind_o),
        .pin_o   (first_route_pin_o),
        .level_o (first_level_o)
    );

    assign amp_bypass_o = amplifier_config[`AFC_BYPASS_BIT];
    assign gain_o       = 8'h01 << amplifier_config[`AFC_GAIN_MSB:0];
    // inputs 5-9 are passed through; only the ten-input variant wires them
    assign positive_input_select_o = input_selector[7:`AFC_HI_LSB];
    assign negative_input_select_o = input_selector[3:0];
endmodule // afc_regs

/* File: afc_regs_assertions.sv */
/* concurrent checks on the afc_regs ports
   assumes a single clock and the bind below */
`timescale 1ns/1ps
module afc_regs_chk
    import afc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic               clk_i,  // clock
    input wire logic               rst_i,  // sync reset
    input wire logic               cyc_i,  // cycle
    input wire logic               stb_i,  // strobe
    input wire logic               we_i,   // write
    input wire logic [ADDR_W-1:0]  adr_i,  // address
    input wire logic [3:0]         sel_i,  // lanes
    input wire logic [31:0]        dat_i,  // write data
    input wire logic [31:0]        dat_o,  // read data
    input wire logic               ack_o,  // ack
    input wire logic               err_o,  // error
    input wire afc_route_kind_type second_route_kind_o, // kind
    input wire logic [9:0]         second_route_pin_o,  // pin
    input wire logic [3:0]         second_level_o,      // level
    input wire logic [3:0]         first_level_o,       // level
    input wire logic               amp_bypass_o,        // bypass
    input wire logic [7:0]         gain_o,              // gain
    input wire logic [3:0]         positive_input_select_o, // positive
    input wire logic [3:0]         negative_input_select_o  // negative
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic w_lo = we_i && sel_i[0];
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    ans_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i)) else $error("no req");
    ack_err_a: assert property (!(ack_o && err_o)) else $error("ack with err");
    rsvd_zero_a: assert property (ack_o && $past(!we_i && adr_i == 8'h3c) |-> dat_o == 32'h0)
        else $error("reserved not zero");
    rst_val_a: assert property ($past(rst_i) |-> second_route_kind_o == AFC_ROUTE_NONE
        && second_level_o == 4'h0 && first_level_o == 4'h0) else $error("bad reset value");
    route_pin_a: assert property ((second_route_kind_o == AFC_ROUTE_INPUT) ?
        $onehot(second_route_pin_o) : second_route_pin_o == 10'h0) else $error("bad pin");
    level_max_a: assert property (second_level_o <= 4'h9 && first_level_o <= 4'ha)
        else $error("level out of range");
    gain_hot_a: assert property ($onehot(gain_o)) else $error("gain not one-hot");
    bypass_wr_a: assert property (ack_o && $past(w_lo && adr_i == 8'h40) |->
        amp_bypass_o == $past(dat_i[7])) else $error("bypass not written");
    sel_wr_a: assert property (ack_o && $past(w_lo && adr_i == 8'h44) |->
        {positive_input_select_o, negative_input_select_o} == $past(dat_i[7:0]))
        else $error("selector not written");
    c_wr: cover property (ack_o && $past(we_i));
    c_rd: cover property (ack_o && $past(!we_i));
    c_err: cover property (err_o);
endmodule // afc_regs_chk
bind afc_regs afc_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

/* File: testbench.sv */
/* bench for afc_regs over classic wishbone
   assumes afc_pkg and the checker are compiled first */
`timescale 1ns/1ps
module testbench
    import afc_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, er;
    logic [3:0]  sel = 4'h1;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wd = 32'h0, rd;
    int          fails = 0, checks = 0;
    wire logic [31:0]        dat_o;
    wire logic               ack_o, err_o, byp;
    wire afc_route_kind_type k2, k1;
    wire logic [9:0]         p2, p1;
    wire logic [3:0]         l2, l1, pos, neg;
    wire logic [7:0]         gain;
    afc_regs i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .second_route_kind_o(k2), .second_route_pin_o(p2), .second_level_o(l2),
        .first_route_kind_o(k1), .first_route_pin_o(p1), .first_level_o(l1),
        .amp_bypass_o(byp), .gain_o(gain), .positive_input_select_o(pos),
        .negative_input_select_o(neg));
    initial forever #5 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // holds the request until the answer edge; only the watchdog ends a hang
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        er = err_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk("read", e, rd);
    endtask
    function automatic logic [31:0] xr(input logic [3:0] n);
        if (n < 4'ha) return {20'h0, AFC_ROUTE_INPUT, 10'h1 << n};
        return {20'h0, (n == 4'ha) ? AFC_ROUTE_COMMON : AFC_ROUTE_NONE, 10'h0};
    endfunction
    initial begin
        #100000;
        fails++;
        $display("Error watchdog expected 1 seen 0");
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h34, 32'hff);
        rdchk(8'h38, 32'h0);
        rdchk(8'h40, 32'h0);
        rdchk(8'h44, 32'hff);
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, 8'h34, 32'(c * 16 + 15 - c));
            chk("route2", xr(4'(c)), {20'h0, k2, p2});
            chk("route1", xr(4'(15 - c)), {20'h0, k1, p1});
            acc(1'b1, 8'h38, 32'(c * 17));
            chk("level2", 32'((c < 10) ? c : 0), 32'(l2));
            chk("level1", 32'((c < 11) ? c : 0), 32'(l1));
            rdchk(8'h38, 32'(c * 17));
        end
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, 8'h40, 32'((c % 2) * 128 + c));
            chk("gain", 32'(1 << c), 32'(gain));
            chk("bypass", 32'(c % 2), 32'(byp));
        end
        acc(1'b1, 8'h44, 32'h5b);
        chk("inputs", 32'h5b, {24'h0, pos, neg});
        sel <= 4'h0;
        acc(1'b1, 8'h44, 32'ha0);
        sel <= 4'h1;
        rdchk(8'h44, 32'h5b);
        acc(1'b1, 8'h3c, 32'hff);
        rdchk(8'h3c, 32'h0);
        acc(1'b0, 8'h48, 32'h0);
        chk("err", 32'h1, 32'(er));
        acc(1'b1, 8'h35, 32'h0);
        chk("err", 32'h1, 32'(er));
        rdchk(8'h34, 32'hf0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h34, 32'hff);
        rdchk(8'h38, 32'h0);
        wrap_up();
    end
endmodule // testbench
